// >>> verilog/fsq_pkg.sv
// Constants shared by the flash self-program sequencer.
// Assumes a 100 MHz core clock and a 32-bit APB register bus.
package fsq_pkg;
	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] FSQ_CTRL_OFS   = 8'h00;
	localparam logic [7:0] FSQ_UNLOCK_OFS = 8'h04;
	localparam logic [7:0] FSQ_PTR_OFS    = 8'h08;
	localparam logic [7:0] FSQ_LATCH_OFS  = 8'h0C;
	localparam logic [7:0] FSQ_OP_OFS     = 8'h10;
	localparam logic [7:0] FSQ_STAT_OFS   = 8'h14;
	// ------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------
	localparam int CTRL_REGION_BIT = 7;
	localparam int CTRL_CFG_BIT    = 6;
	localparam int CTRL_ERASE_BIT  = 4;
	localparam int CTRL_ABORT_BIT  = 3;
	localparam int CTRL_PEN_BIT    = 2;
	localparam int CTRL_GO_BIT     = 1;
	localparam int STAT_DONE_BIT   = 4;
	localparam int OP_STORE_BIT    = 2;
	// ------------------------------------------------------------
	// Pointer fetch/store variants and unlock keys
	// ------------------------------------------------------------
	localparam logic [1:0] VAR_KEEP    = 2'h0;
	localparam logic [1:0] VAR_POSTINC = 2'h1;
	localparam logic [1:0] VAR_POSTDEC = 2'h2;
	localparam logic [1:0] VAR_PREINC  = 2'h3;
	localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
	localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
	localparam logic [7:0] HOLD_BLANK  = 8'hFF;
	// ------------------------------------------------------------
	// Geometry and timing
	// ------------------------------------------------------------
	localparam int PTR_W      = 22;
	localparam int ROW_LSB    = 6;
	localparam int ROW_W      = 16;
	localparam int ROW_BYTES  = 64;
	localparam int CLK_MHZ    = 100;
	localparam int EP_TIME_US = 1000;
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_RUN  = 2'b01,
		SEQ_WAIT = 2'b11,
		SEQ_DONE = 2'b10
	} fsq_seq_e;
endpackage : fsq_pkg

// >>> verilog/fsq_sequencer.sv
// Flash self-program sequencer: byte fetch, row erase, row program.
// Assumes an APB master, a flash macro with one-cycle read latency,
// and a power-on reset separate from the device reset.
//
// Summary of operation
// - Table fetch moves one byte only
// - Fetch copies pointed byte into latch
// - Pointer bit zero picks word half
// - Erase unit is one 64-byte row
// - No bulk erase beyond one row
// - Erase row from pointer bits 21:6
// - Erase needs region, enable, erase select
// - Start only after 55h, AAh unlock
// - Go after unlock with erase starts erase
// - Stall core until programming timer ends
// - Program unit is one 64-byte row
// - Sixty-four holding bytes loaded from latch
// - Store op writes holding register only
// - Holding bytes blank on reset, after program
// - Blank holding byte leaves flash unchanged
// - Go cleared by hardware at completion
// - Done flag set at completion, software clears
// - Low bits pick holding byte, high row
// - Abort flag on device reset mid-write or improper start
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module fsq_sequencer
	import fsq_pkg::*;
#(
	parameter int EP_CYCLES = EP_TIME_US * CLK_MHZ
) (
	// Clock and resets
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             por_n,
	// APB slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	// Core stall
	output logic                  cpu_stall,
	// Flash macro read port
	output logic                  fl_rd_en,
	output logic      [PTR_W-2:0] fl_rd_addr,
	input  wire logic [15:0]      fl_rdata,
	// Flash macro erase and program port
	output logic                  fl_erase,
	output logic      [ROW_W-1:0] fl_row,
	output logic                  fl_wr_en,
	output logic      [PTR_W-1:0] fl_wr_addr,
	output logic      [7:0]       fl_wr_data
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	localparam logic [31:0] EP_CNT = 32'(EP_CYCLES);
	localparam logic [5:0]  LAST_IDX = 6'(ROW_BYTES - 1);

	// Modify only the low 21 bits; bit 21 selects id/config space
	function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p,
			input logic dec);
		logic [PTR_W-2:0] lo;
		lo = dec ? p[PTR_W-2:0] - 1'b1 : p[PTR_W-2:0] + 1'b1;
		ptr_step = {p[PTR_W-1], lo};
	endfunction : ptr_step

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [PTR_W-1:0] ptr_r;
	logic [7:0]       latch_r;
	logic [7:0]       hold_r [ROW_BYTES];
	logic             region_r;
	logic             cfg_r;
	logic             erase_r;
	logic             pen_r;
	logic             go_r;
	logic             abort_r;
	logic             done_r;
	logic             was_busy_r;
	logic             boot_chk_r;
	logic             busy_q_r;
	logic [1:0]       unl_r;
	logic [1:0]       fst_r;
	logic [1:0]       fvar_r;
	logic [5:0]       idx_r;
	logic [31:0]      tmr_r;
	fsq_seq_e         seq_r;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic busy;
	logic setup;
	logic acc;
	logic done_acc;
	logic wr_done;
	logic is_op;
	logic is_fetch;
	logic mapped;
	logic go_req;
	logic start_ok;
	logic [PTR_W-1:0] eff_ptr;
	logic [PTR_W-1:0] post_ptr;

	assign busy     = (seq_r != SEQ_IDLE);
	assign setup    = psel & ~penable;
	assign acc      = psel & penable;
	assign is_op    = pwrite & (paddr == FSQ_OP_OFS);
	assign is_fetch = is_op & ~pwdata[OP_STORE_BIT];
	// Stalled core waits out the long write, plus one cycle to refresh prdata
	assign pready   = ~busy & ~busy_q_r & (~is_fetch | fst_r == 2'h3);
	assign done_acc = acc & pready;
	assign wr_done  = done_acc & pwrite;
	assign mapped   = paddr == FSQ_CTRL_OFS || paddr == FSQ_UNLOCK_OFS ||
		paddr == FSQ_PTR_OFS || paddr == FSQ_LATCH_OFS ||
		paddr == FSQ_OP_OFS || paddr == FSQ_STAT_OFS;
	assign pslverr  = done_acc & ~mapped;
	assign cpu_stall = busy;

	assign go_req = wr_done & (paddr == FSQ_CTRL_OFS) &
		pwdata[CTRL_GO_BIT] & ~go_r;
	// Target must be program memory, writes enabled, unlock armed
	assign start_ok = (unl_r == 2'h2) & pen_r & region_r & ~cfg_r;

	// Pre-increment applies before the byte is used
	assign eff_ptr  = (pwdata[1:0] == VAR_PREINC) ? ptr_step(ptr_r, 1'b0) : ptr_r;
	always_comb begin
		unique case (pwdata[1:0])
			VAR_POSTINC: post_ptr = ptr_step(eff_ptr, 1'b0);
			VAR_POSTDEC: post_ptr = ptr_step(eff_ptr, 1'b1);
			default:     post_ptr = eff_ptr;
		endcase
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if ((setup || (acc && !pready)) && !pwrite) begin
			unique case (paddr)
				FSQ_CTRL_OFS: prdata <= 32'({region_r, cfg_r, 1'b0, erase_r,
					abort_r, pen_r, go_r, 1'b0});
				FSQ_PTR_OFS:   prdata <= 32'(ptr_r);
				FSQ_LATCH_OFS: prdata <= 32'(latch_r);
				FSQ_STAT_OFS:  prdata <= 32'({done_r, 4'h0});
				default:       prdata <= 32'h0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Unlock tracking
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unl_r <= 2'h0;
		end else if (done_acc) begin
			if (pwrite && paddr == FSQ_UNLOCK_OFS && pwdata[7:0] == UNLOCK_KEY1)
				unl_r <= 2'h1;
			else if (pwrite && paddr == FSQ_UNLOCK_OFS &&
					pwdata[7:0] == UNLOCK_KEY2 && unl_r == 2'h1)
				unl_r <= 2'h2;
			else
				unl_r <= 2'h0;
		end
	end

	// ------------------------------------------------------------
	// Control bits
	// ------------------------------------------------------------
	// Memory selects survive device reset so a failed cycle is traceable
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			region_r <= 1'b0;
			cfg_r    <= 1'b0;
		end else if (wr_done && paddr == FSQ_CTRL_OFS && !go_r) begin
			region_r <= pwdata[CTRL_REGION_BIT];
			cfg_r    <= pwdata[CTRL_CFG_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pen_r   <= 1'b0;
			erase_r <= 1'b0;
		end else if (seq_r == SEQ_DONE) begin
			erase_r <= 1'b0;
		end else if (wr_done && paddr == FSQ_CTRL_OFS) begin
			pen_r   <= pwdata[CTRL_PEN_BIT];
			erase_r <= pwdata[CTRL_ERASE_BIT];
		end
	end

	// Software may only set go; hardware clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			go_r <= 1'b0;
		else if (seq_r == SEQ_DONE)
			go_r <= 1'b0;
		else if (go_req && start_ok)
			go_r <= 1'b1;
	end

	// Tracks a long write across device reset
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n)
			was_busy_r <= 1'b0;
		else if (!boot_chk_r || seq_r == SEQ_DONE)
			was_busy_r <= 1'b0;
		else if (go_req && start_ok)
			was_busy_r <= 1'b1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_chk_r <= 1'b0;
			busy_q_r   <= 1'b0;
		end else begin
			boot_chk_r <= 1'b1;
			busy_q_r   <= busy;
		end
	end
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n)
			abort_r <= 1'b0;
		else if (!boot_chk_r && was_busy_r)
			abort_r <= 1'b1;
		else if (go_req)
			abort_r <= ~start_ok;
		else if (seq_r == SEQ_DONE)
			abort_r <= 1'b0;
	end
	// Set wins over a same-cycle write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			done_r <= 1'b0;
		else if (seq_r == SEQ_DONE)
			done_r <= 1'b1;
		else if (wr_done && paddr == FSQ_STAT_OFS && pwdata[STAT_DONE_BIT])
			done_r <= 1'b0;
	end

	// ------------------------------------------------------------
	// Pointer, latch and byte fetch
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fst_r  <= 2'h0;
			fvar_r <= VAR_KEEP;
		end else if (acc && is_fetch && !busy) begin
			unique case (fst_r)
				2'h0: begin
					fst_r  <= 2'h1;
					fvar_r <= pwdata[1:0];
				end
				2'h1: fst_r <= 2'h2;
				2'h2: fst_r <= 2'h3;
				2'h3: fst_r <= 2'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fl_rd_en   <= 1'b0;
			fl_rd_addr <= '0;
		end else begin
			fl_rd_en <= acc && is_fetch && !busy && fst_r == 2'h0;
			if (acc && is_fetch && !busy && fst_r == 2'h0)
				fl_rd_addr <= eff_ptr[PTR_W-1:1];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_r <= '0;
		end else if (wr_done && paddr == FSQ_PTR_OFS) begin
			ptr_r <= pwdata[PTR_W-1:0];
		end else if (acc && is_fetch && !busy && fst_r == 2'h0) begin
			ptr_r <= eff_ptr;
		end else if (acc && is_fetch && !busy && fst_r == 2'h2) begin
			if (fvar_r == VAR_POSTINC)
				ptr_r <= ptr_step(ptr_r, 1'b0);
			else if (fvar_r == VAR_POSTDEC)
				ptr_r <= ptr_step(ptr_r, 1'b1);
		end else if (wr_done && is_op && pwdata[OP_STORE_BIT]) begin
			ptr_r <= post_ptr;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			latch_r <= 8'h0;
		else if (acc && is_fetch && !busy && fst_r == 2'h2)
			latch_r <= ptr_r[0] ? fl_rdata[15:8] : fl_rdata[7:0];
		else if (wr_done && paddr == FSQ_LATCH_OFS)
			latch_r <= pwdata[7:0];
	end

	// ------------------------------------------------------------
	// Holding registers
	// ------------------------------------------------------------
	// Store op is a short write: array untouched until go
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < ROW_BYTES; i++)
				hold_r[i] <= HOLD_BLANK;
		end else if (seq_r == SEQ_DONE && !erase_r) begin
			for (int i = 0; i < ROW_BYTES; i++)
				hold_r[i] <= HOLD_BLANK;
		end else if (wr_done && is_op && pwdata[OP_STORE_BIT]) begin
			hold_r[eff_ptr[ROW_LSB-1:0]] <= latch_r;
		end
	end

	// ------------------------------------------------------------
	// Long write sequence
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_r <= SEQ_IDLE;
			idx_r <= 6'h0;
			tmr_r <= 32'h0;
		end else begin
			unique case (seq_r)
				SEQ_IDLE: if (go_req && start_ok) begin
					seq_r <= SEQ_RUN;
					idx_r <= 6'h0;
				end
				SEQ_RUN: if (erase_r || idx_r == LAST_IDX) begin
					seq_r <= SEQ_WAIT;
					tmr_r <= EP_CNT;
				end else begin
					idx_r <= idx_r + 1'b1;
				end
				SEQ_WAIT: begin
					tmr_r <= tmr_r - 1'b1;
					if (tmr_r <= 32'h1)
						seq_r <= SEQ_DONE;
				end
				SEQ_DONE: seq_r <= SEQ_IDLE;
			endcase
		end
	end

	// Whole-row erase only; no wider or narrower erase exists
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fl_erase <= 1'b0;
			fl_row   <= '0;
		end else begin
			fl_erase <= seq_r == SEQ_RUN && erase_r;
			if (seq_r == SEQ_IDLE)
				fl_row <= ptr_r[PTR_W-1:ROW_LSB];
		end
	end

	// Blank holding bytes are skipped, so bits only ever clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fl_wr_en   <= 1'b0;
			fl_wr_addr <= '0;
			fl_wr_data <= 8'h0;
		end else begin
			fl_wr_en   <= seq_r == SEQ_RUN && !erase_r &&
				hold_r[idx_r] != HOLD_BLANK;
			fl_wr_addr <= {fl_row, idx_r};
			fl_wr_data <= hold_r[idx_r];
		end
	end

endmodule : fsq_sequencer

// >>> dv/fsq_properties.sv
// Concurrent checks on the sequencer's top-level ports.
// Bound from tb; EP_CYCLES must match the bound instance.
`timescale 1ns/1ps
module fsq_properties
	import fsq_pkg::*;
#(
	parameter int EP_CYCLES = 20
) (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	// Stall and flash
	input wire logic        cpu_stall,
	input wire logic        fl_rd_en,
	input wire logic        fl_erase,
	input wire logic        fl_wr_en,
	input wire logic [7:0]  fl_wr_data
);
	logic        wr_done;
	logic        go_wr;
	logic [15:0] stall_cnt_r;
	assign wr_done = psel && penable && pready && pwrite;
	assign go_wr   = wr_done && paddr == FSQ_CTRL_OFS && pwdata[CTRL_GO_BIT];
	// Stall length, cleared whenever the core runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stall_cnt_r <= 16'h0000;
		else if (cpu_stall)
			stall_cnt_r <= stall_cnt_r + 16'h0001;
		else
			stall_cnt_r <= 16'h0000;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----
	// Properties
	// ----
	sequence s_key(logic [7:0] k);
		wr_done && paddr == FSQ_UNLOCK_OFS && pwdata[7:0] == k;
	endsequence
	sequence s_go;
		go_wr && pwdata[CTRL_PEN_BIT] && pwdata[CTRL_REGION_BIT] && !pwdata[CTRL_CFG_BIT] && !cpu_stall;
	endsequence
	property p_fetch;
		psel && !penable && pwrite && paddr == FSQ_OP_OFS && !pwdata[OP_STORE_BIT] && !cpu_stall
		|=> !pready ##1 (fl_rd_en && !pready) ##1 !pready ##1 pready;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch timing wrong");
	property p_unlock;
		s_key(UNLOCK_KEY1) ##[2:4] s_key(UNLOCK_KEY2) ##[2:4] s_go |-> ##[1:3] cpu_stall;
	endproperty
	a_unlock: assert property (p_unlock) else $error("unlocked go did not start");
	property p_cause;
		$rose(cpu_stall) |-> $past(go_wr) || $past(go_wr, 2);
	endproperty
	a_cause: assert property (p_cause) else $error("stall without go write");
	property p_stall_wait;
		cpu_stall && psel && penable |-> !pready;
	endproperty
	a_stall_wait: assert property (p_stall_wait) else $error("access finished during stall");
	property p_stall_len;
		$fell(cpu_stall) |-> stall_cnt_r >= EP_CYCLES && stall_cnt_r <= EP_CYCLES + ROW_BYTES + 4;
	endproperty
	a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
	property p_long_only;
		fl_wr_en || fl_erase |-> cpu_stall;
	endproperty
	a_long_only: assert property (p_long_only) else $error("array changed outside long write");
	property p_blank;
		fl_wr_en |-> fl_wr_data != HOLD_BLANK;
	endproperty
	a_blank: assert property (p_blank) else $error("blank byte programmed");
	property p_one_row;
		fl_erase |=> !fl_erase [*8];
	endproperty
	a_one_row: assert property (p_one_row) else $error("more than one row erased");
endmodule : fsq_properties

// >>> dv/fsq_flash_model.sv
// Behavioural flash macro on the sequencer's far side.
// One-cycle read latency; records erases and byte writes.
`timescale 1ns/1ps
module fsq_flash_model (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Read port
	input wire logic        fl_rd_en,
	input wire logic [20:0] fl_rd_addr,
	output logic     [15:0] fl_rdata,
	// Erase and program port
	input wire logic        fl_erase,
	input wire logic [15:0] fl_row,
	input wire logic        fl_wr_en,
	input wire logic [21:0] fl_wr_addr,
	input wire logic [7:0]  fl_wr_data
);
	int          n_erase = 0;
	int          n_wr = 0;
	logic [15:0] erase_row;
	logic [21:0] wa [2];
	logic [7:0]  wd [2];
	// Data toggles outside the valid cycle so a late sample shows
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fl_rdata <= 16'h5AA5;
		else if (fl_rd_en)
			fl_rdata <= {~fl_rd_addr[7:0], fl_rd_addr[7:0]};
		else
			fl_rdata <= ~fl_rdata;
	end
	always_ff @(posedge pclk) begin
		if (fl_erase) begin
			n_erase <= n_erase + 1;
			erase_row <= fl_row;
		end
		if (fl_wr_en) begin
			n_wr <= n_wr + 1;
			wa[n_wr[0]] <= fl_wr_addr;
			wd[n_wr[0]] <= fl_wr_data;
		end
	end
endmodule : fsq_flash_model

// >>> dv/tb.sv
// Self-checking bench for the flash self-program sequencer.
// Drives APB as the core, flash side is fsq_flash_model.
`timescale 1ns/1ps
module tb;
	import fsq_pkg::*;
	typedef struct packed {logic [21:0] ptr; logic [1:0] vr; logic [7:0] byt; logic [21:0] nptr;} fsq_case_s;
	logic        pclk = 1'b0;
	logic        presetn, por_n, psel, penable, pwrite, pready, pslverr, cpu_stall, err;
	logic        fl_rd_en, fl_erase, fl_wr_en;
	logic [7:0]  paddr, fl_wr_data;
	logic [31:0] pwdata, prdata, rd;
	logic [20:0] fl_rd_addr;
	logic [15:0] fl_rdata, fl_row;
	logic [21:0] fl_wr_addr;
	int          n_mismatch = 0;
	int          comparisons = 0;
	int          cyc = 0;
	fsq_case_s   rows [5] = '{
		'{22'h000100, VAR_KEEP, 8'h80, 22'h000100},
		'{22'h000101, VAR_POSTINC, 8'h7F, 22'h000102},
		'{22'h000203, VAR_POSTDEC, 8'hFE, 22'h000202},
		'{22'h0000FF, VAR_PREINC, 8'h80, 22'h000100},
		'{22'h3FFFFF, VAR_PREINC, 8'h00, 22'h200000}};
	fsq_sequencer #(.EP_CYCLES(20)) dut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_stall(cpu_stall), .fl_rd_en(fl_rd_en), .fl_rd_addr(fl_rd_addr),
		.fl_rdata(fl_rdata), .fl_erase(fl_erase), .fl_row(fl_row), .fl_wr_en(fl_wr_en),
		.fl_wr_addr(fl_wr_addr), .fl_wr_data(fl_wr_data));
	fsq_flash_model u_fl (.pclk(pclk), .presetn(presetn), .fl_rd_en(fl_rd_en), .fl_rd_addr(fl_rd_addr),
		.fl_rdata(fl_rdata), .fl_erase(fl_erase), .fl_row(fl_row), .fl_wr_en(fl_wr_en),
		.fl_wr_addr(fl_wr_addr), .fl_wr_data(fl_wr_data));
	always #5 pclk = ~pclk;
	// ----
	// Tasks
	// ----
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	// Ready and data are read at the sampling edge, before its own updates land
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		logic rdy;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			rdy = pready;
		end while (rdy !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic start(input logic [7:0] c);
		apb(1'b1, FSQ_CTRL_OFS, {24'h0, c});
		apb(1'b1, FSQ_UNLOCK_OFS, 32'h55);
		apb(1'b1, FSQ_UNLOCK_OFS, 32'hAA);
		apb(1'b1, FSQ_CTRL_OFS, {24'h0, c | 8'h02});
	endtask : start
	task automatic test_done;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			test_done();
		end
	end
	initial begin
		presetn = 1'b0;
		por_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		apb(1'b0, FSQ_CTRL_OFS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk(err, 32'h1);
		chk(rd, 32'h0);
		foreach (rows[i]) begin
			apb(1'b1, FSQ_PTR_OFS, {10'h0, rows[i].ptr});
			apb(1'b1, FSQ_OP_OFS, {30'h0, rows[i].vr});
			apb(1'b0, FSQ_LATCH_OFS, 32'h0);
			chk(rd, {24'h0, rows[i].byt});
			apb(1'b0, FSQ_PTR_OFS, 32'h0);
			chk(rd, {10'h0, rows[i].nptr});
		end
		// Refused starts: no enable, then a read inside the unlock
		start(8'h90);
		apb(1'b1, FSQ_CTRL_OFS, 32'h84);
		apb(1'b1, FSQ_UNLOCK_OFS, 32'h55);
		apb(1'b0, FSQ_STAT_OFS, 32'h0);
		apb(1'b1, FSQ_UNLOCK_OFS, 32'hAA);
		apb(1'b1, FSQ_CTRL_OFS, 32'h86);
		repeat (4) @(posedge pclk);
		chk(cpu_stall, 32'h0);
		chk(u_fl.n_erase, 32'h0);
		apb(1'b0, FSQ_CTRL_OFS, 32'h0);
		chk(rd & 32'h8, 32'h8);
		// Row erase; pointer low bits must not matter
		apb(1'b1, FSQ_PTR_OFS, 32'h12C5);
		start(8'h94);
		apb(1'b0, FSQ_STAT_OFS, 32'h0);
		chk(rd, 32'h10);
		chk(u_fl.n_erase, 32'h1);
		chk(u_fl.erase_row, 32'h4B);
		apb(1'b0, FSQ_CTRL_OFS, 32'h0);
		chk(rd, 32'h84);
		apb(1'b1, FSQ_STAT_OFS, 32'h10);
		apb(1'b0, FSQ_STAT_OFS, 32'h0);
		chk(rd, 32'h0);
		// Partial row program, two bytes staged
		apb(1'b1, FSQ_PTR_OFS, 32'h841);
		apb(1'b1, FSQ_LATCH_OFS, 32'h3C);
		apb(1'b1, FSQ_OP_OFS, 32'h5);
		apb(1'b1, FSQ_LATCH_OFS, 32'hA5);
		apb(1'b1, FSQ_OP_OFS, 32'h4);
		chk(u_fl.n_wr, 32'h0);
		start(8'h84);
		apb(1'b0, FSQ_STAT_OFS, 32'h0);
		chk(u_fl.n_wr, 32'h2);
		chk(u_fl.wa[0], 32'h841);
		chk(u_fl.wd[0], 32'h3C);
		chk(u_fl.wa[1], 32'h842);
		chk(u_fl.wd[1], 32'hA5);
		start(8'h84);
		apb(1'b0, FSQ_STAT_OFS, 32'h0);
		chk(u_fl.n_wr, 32'h2);
		// Device reset in mid erase
		start(8'h94);
		repeat (5) @(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, FSQ_CTRL_OFS, 32'h0);
		chk(rd & 32'h8A, 32'h88);
		test_done();
	end
endmodule : tb
bind fsq_sequencer fsq_properties #(.EP_CYCLES(EP_CYCLES)) u_prop (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.cpu_stall(cpu_stall), .fl_rd_en(fl_rd_en), .fl_erase(fl_erase), .fl_wr_en(fl_wr_en),
	.fl_wr_data(fl_wr_data));
